/* File: hw/tmr_core.sv */
/*
 * 8-bit timer/counter core: clock select, free prescaler, count pin,
 * counter, two compare channels, irq mask and flags, prescaler sync hold.
 * assumes an Avalon-MM master on the system clock and an external vector
 * acknowledge pulse for flag clearing.
 */
// The register addresses and the Avalon-MM slave port are this design's own decisions.
//
// Overview of operation
// - force strobe b acts only in non-pwm modes, applying output b mode.
// - force strobe raises no flag and never clears the counter.
// - force strobe bit always reads as zero.
// - reserved bits of control b, mask and flags read as zero.
// - clock select picks stop, div 1, 8, 64, 256, 1024, pin fall, pin rise.
// - pin modes count transitions even when the pin is an output.
// - counter readable and writable; a write blocks next tick's match.
// - both compare registers compared continuously with the counter.
// - interrupt request when enable, flag and global enable all set.
// - compare flags set on match, cleared by vector or written one.
// - overflow flag set at mode point, cleared by vector or written one.
// - prescaler runs freely, so first prescaled tick comes 1 to N clocks later.
// - pin sampled each clock, edge detected, one tick per chosen edge.
// - pin edge reaches the counter within 2 to 3 clocks.
// - pin clock feeds the counter directly, never the prescaler.
// - sync hold keeps prescaler clear set; leaving it clears the bit.
// - writing prescaler clear resets prescaler; bit self-clears unless hold.
// - overflow at max in normal, ctc, fast and modes 4, 6; bottom in phase; top in mode 7.
`timescale 1ns/100ps
`default_nettype none
`include "tmr_cfg.svh"
module tmr_core
	import tmr_pkg::*;
#(
	parameter int ADDR_W = 6
) (
	input wire logic I_CLOCK,
	input wire logic I_NRST,
	input wire logic [ADDR_W-1:0] I_ADDRESS,
	input wire logic I_READ,
	input wire logic I_WRITE,
	input wire logic [31:0] I_WRITEDATA,
	input wire logic [3:0] I_BYTEENABLE,
	output logic [31:0] O_READDATA,
	output logic O_WAITREQUEST,
	output logic [1:0] O_RESPONSE,
	input wire logic I_EXT_COUNT_PIN,
	input wire logic I_GLOBAL_IRQ_EN,
	input wire logic [2:0] I_VECTOR_ACK,
	output logic [2:0] O_IRQ,
	output logic O_WAVE_OUT_A,
	output logic O_WAVE_OUT_B
);
	if (ADDR_W < 6) begin : g_addr_chk
		$error("tmr_core: ADDR_W must be at least 6");
	end
	// ************************************************************
	// bus slave
	// ************************************************************
	logic [7:0] ctrl_a_q;
	logic [3:0] ctrl_b_q;
	logic [7:0] count_q;
	logic [7:0] cmp_a_q;
	logic [7:0] cmp_b_q;
	logic [2:0] mask_q;
	logic [2:0] flags_q;
	logic hold_q;
	logic psr_q;
	tmr_bus_t bus_q;
	logic [3:0] idx;
	logic acc_ok;
	logic wr_go;
	logic lane0;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	logic hit;
	assign idx = I_ADDRESS[`TMR_ADDR_SHIFT+3:`TMR_ADDR_SHIFT];
	assign lane0 = I_BYTEENABLE[0];
	assign wbyte = I_WRITEDATA[7:0];
	assign acc_ok = (bus_q == TMR_BUS_IDLE) && (I_READ || I_WRITE);
	assign wr_go = (bus_q == TMR_BUS_DONE) && I_WRITE && lane0; // commits as the wait ends
	// register read mux, reserved bits forced low
	always_comb begin
		rbyte = `TMR_RST_BYTE;
		hit = 1'b1;
		if (idx == `TMR_OFF_CTRL_A) begin
			rbyte = ctrl_a_q & `TMR_MASK_CTRL_A;
		end else if (idx == `TMR_OFF_CTRL_B) begin
			rbyte = {4'h0, ctrl_b_q};
		end else if (idx == `TMR_OFF_COUNT) begin
			rbyte = count_q;
		end else if (idx == `TMR_OFF_CMP_A) begin
			rbyte = cmp_a_q;
		end else if (idx == `TMR_OFF_CMP_B) begin
			rbyte = cmp_b_q;
		end else if (idx == `TMR_OFF_MASK) begin
			rbyte = {4'h0, mask_q, 1'b0};
		end else if (idx == `TMR_OFF_FLAGS) begin
			rbyte = {4'h0, flags_q, 1'b0};
		end else if (idx == `TMR_OFF_SYNC) begin
			rbyte = {hold_q, 6'h00, psr_q};
		end else begin
			hit = 1'b0;
		end
	end
	// one wait cycle, answer on the second edge
	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			bus_q <= TMR_BUS_IDLE;
			O_WAITREQUEST <= 1'b1;
			O_READDATA <= 32'h00000000;
			O_RESPONSE <= 2'h0;
		end else begin
			case (bus_q)
				TMR_BUS_IDLE: begin
					if (I_READ || I_WRITE) begin
						bus_q <= TMR_BUS_DONE;
						O_WAITREQUEST <= 1'b0;
						O_READDATA <= {24'h000000, I_READ ? rbyte : 8'h00};
						O_RESPONSE <= hit ? 2'h0 : 2'h3;
					end
				end
				TMR_BUS_DONE: begin
					bus_q <= TMR_BUS_IDLE;
					O_WAITREQUEST <= 1'b1;
				end
				default: begin
					bus_q <= TMR_BUS_IDLE;
					O_WAITREQUEST <= 1'b1;
				end
			endcase
		end
	end
	// plain control registers
	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			ctrl_a_q <= `TMR_RST_BYTE;
			ctrl_b_q <= 4'h0;
			cmp_a_q <= `TMR_RST_BYTE;
			cmp_b_q <= `TMR_RST_BYTE;
			mask_q <= 3'h0;
		end else if (wr_go) begin
			if (idx == `TMR_OFF_CTRL_A) begin
				ctrl_a_q <= wbyte & `TMR_MASK_CTRL_A;
			end else if (idx == `TMR_OFF_CTRL_B) begin
				ctrl_b_q <= wbyte[3:0];
			end else if (idx == `TMR_OFF_CMP_A) begin
				cmp_a_q <= wbyte;
			end else if (idx == `TMR_OFF_CMP_B) begin
				cmp_b_q <= wbyte;
			end else if (idx == `TMR_OFF_MASK) begin
				mask_q <= wbyte[3:1];
			end
		end
	end
	// ************************************************************
	// mode decode
	// ************************************************************
	logic [2:0] wave_mode_bits;
	logic pwm_mode;
	logic phase_mode;
	logic ctc_mode;
	logic top_is_a;
	logic [7:0] top_val;
	tmr_clk_sel_t cs;
	assign wave_mode_bits = {ctrl_b_q[`TMR_CB_WGM_HI], ctrl_a_q[`TMR_CA_WGM_LSB+1:`TMR_CA_WGM_LSB]};
	assign pwm_mode = wave_mode_bits[0];
	assign phase_mode = (wave_mode_bits == 3'h1) || (wave_mode_bits == 3'h5);
	assign ctc_mode = (wave_mode_bits == 3'h2);
	assign top_is_a = ctc_mode || (wave_mode_bits == 3'h5) || (wave_mode_bits == 3'h7);
	assign top_val = top_is_a ? cmp_a_q : `TMR_VAL_MAX;
	assign cs = tmr_clk_sel_t'(ctrl_b_q[`TMR_CB_CS_LSB+2:`TMR_CB_CS_LSB]);
	// ************************************************************
	// prescaler and clock select
	// ************************************************************
	logic [`TMR_PRE_W-1:0] pre_q;
	logic pin_edge;
	logic tick;
	// free running divider, held clear only by the reset bit
	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			pre_q <= '0;
		end else if (psr_q) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + 1'b1;
		end
	end
	// sync hold and prescaler clear bits
	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			hold_q <= 1'b0;
			psr_q <= 1'b0;
		end else if (wr_go && idx == `TMR_OFF_SYNC) begin
			hold_q <= wbyte[`TMR_SYNC_HOLD];
			psr_q <= wbyte[`TMR_SYNC_PSR] | (hold_q & psr_q & wbyte[`TMR_SYNC_HOLD]);
		end else if (!hold_q) begin
			psr_q <= 1'b0;
		end
	end
	tmr_pin_sync u_pin (
		.i_clk(I_CLOCK),
		.i_nrst(I_NRST),
		.i_pin(I_EXT_COUNT_PIN),
		.i_fall_sel(cs == TMR_CS_EXT_FALL),
		.o_edge(pin_edge)
	);
	function automatic logic tap_hit(input logic [`TMR_PRE_W-1:0] cnt,
		input logic [`TMR_PRE_W-1:0] tap);
		tap_hit = ((cnt & tap) == tap);
	endfunction : tap_hit
	// timer tick from the selected source
	always_comb begin
		case (cs)
			TMR_CS_STOP: tick = 1'b0;
			TMR_CS_DIV1: tick = 1'b1;
			TMR_CS_DIV8: tick = tap_hit(pre_q, `TMR_TAP_8);
			TMR_CS_DIV64: tick = tap_hit(pre_q, `TMR_TAP_64);
			TMR_CS_DIV256: tick = tap_hit(pre_q, `TMR_TAP_256);
			TMR_CS_DIV1024: tick = tap_hit(pre_q, `TMR_TAP_1024);
			default: tick = pin_edge;
		endcase
	end
	// ************************************************************
	// counter and compare
	// ************************************************************
	logic down_q;
	logic block_q;
	logic cnt_wr;
	logic match_a;
	logic match_b;
	logic ovf_ev;
	logic force_b;
	assign cnt_wr = wr_go && (idx == `TMR_OFF_COUNT);
	assign force_b = wr_go && (idx == `TMR_OFF_CTRL_B) && wbyte[`TMR_CB_FORCE_B] && !pwm_mode;
	assign match_a = tick && !block_q && (count_q == cmp_a_q);
	assign match_b = tick && !block_q && (count_q == cmp_b_q);
	// overflow point per waveform mode
	always_comb begin
		ovf_ev = 1'b0;
		if (tick) begin
			if (phase_mode) begin
				ovf_ev = (count_q == `TMR_VAL_BOTTOM) && down_q;
			end else if (wave_mode_bits == 3'h7) begin
				ovf_ev = (count_q == top_val);
			end else begin
				ovf_ev = (count_q == `TMR_VAL_MAX);
			end
		end
	end
	// counter with direction for phase correct modes
	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			count_q <= `TMR_RST_BYTE;
			down_q <= 1'b0;
		end else if (cnt_wr) begin
			count_q <= wbyte;
		end else if (tick) begin
			if (phase_mode) begin
				if (!down_q && count_q >= top_val) begin
					down_q <= 1'b1;
					count_q <= count_q - 1'b1;
				end else if (down_q && count_q == `TMR_VAL_BOTTOM) begin
					down_q <= 1'b0;
					count_q <= count_q + 1'b1;
				end else begin
					count_q <= down_q ? count_q - 1'b1 : count_q + 1'b1;
				end
			end else if (top_is_a && count_q == top_val) begin
				count_q <= `TMR_VAL_BOTTOM;
			end else begin
				count_q <= count_q + 1'b1;
			end
		end
	end
	// write to counter blocks the match on the next tick
	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			block_q <= 1'b0;
		end else if (cnt_wr) begin
			block_q <= 1'b1;
		end else if (tick) begin
			block_q <= 1'b0;
		end
	end
	// ************************************************************
	// flags and interrupt requests
	// ************************************************************
	logic [2:0] set_ev;
	logic [2:0] clr_ev;
	assign set_ev = {match_b, match_a, ovf_ev};
	assign clr_ev = I_VECTOR_ACK | ((wr_go && idx == `TMR_OFF_FLAGS) ? wbyte[3:1] : 3'h0);
	// set wins over any clear in the same cycle
	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			flags_q <= 3'h0;
		end else begin
			flags_q <= (flags_q & ~clr_ev) | set_ev;
		end
	end
	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			O_IRQ <= 3'h0;
		end else begin
			O_IRQ <= flags_q & mask_q & {3{I_GLOBAL_IRQ_EN}};
		end
	end
	// ************************************************************
	// waveform outputs
	// ************************************************************
	function automatic logic wave_next(input logic cur, input logic [1:0] mode,
		input logic hit, input logic at_top, input logic pwm, input logic phase,
		input logic dn);
		wave_next = cur;
		if (hit) begin
			case (mode)
				2'h1: wave_next = pwm ? cur : ~cur;
				2'h2: wave_next = phase ? dn : 1'b0;
				2'h3: wave_next = phase ? ~dn : 1'b1;
				default: wave_next = cur;
			endcase
		end else if (at_top && pwm && !phase && mode[1]) begin
			wave_next = ~mode[0];
		end
	endfunction : wave_next
	logic at_top;
	assign at_top = tick && !phase_mode && (count_q == top_val);
	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			O_WAVE_OUT_A <= 1'b0;
			O_WAVE_OUT_B <= 1'b0;
		end else begin
			O_WAVE_OUT_A <= wave_next(O_WAVE_OUT_A, ctrl_a_q[`TMR_CA_COMA_LSB+1:`TMR_CA_COMA_LSB],
				match_a, at_top, pwm_mode, phase_mode, down_q);
			O_WAVE_OUT_B <= wave_next(O_WAVE_OUT_B, ctrl_a_q[`TMR_CA_COMB_LSB+1:`TMR_CA_COMB_LSB],
				match_b || force_b, at_top, pwm_mode, phase_mode, down_q);
		end
	end
	// ************************************************************
	// assertions
	// ************************************************************
	sequence cnt_write_s;
		cnt_wr;
	endsequence
	force_noflag_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		force_b && !match_b |=> flags_q[2] == $past(flags_q[2]) || $past(I_VECTOR_ACK[2])
			|| $past(clr_ev[2])) else $error("force strobe set a flag");
	force_rdzero_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		I_READ && idx == `TMR_OFF_CTRL_B && acc_ok |=> O_READDATA[7:4] == 4'h0)
		else $error("force bit read nonzero");
	cnt_arm_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		cnt_write_s |=> block_q) else $error("counter write did not arm the block");
	cnt_block_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		block_q && tick |-> !match_a && !match_b) else $error("match after counter write");
	flag_set_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		set_ev[1] |=> flags_q[1]) else $error("compare a flag lost");
	irq_req_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		flags_q[0] && mask_q[0] && I_GLOBAL_IRQ_EN |=> O_IRQ[0])
		else $error("overflow request missing");
	psr_clear_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		psr_q && !hold_q && !wr_go |=> !psr_q) else $error("prescaler clear stuck");
	hold_keep_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		psr_q && hold_q && !wr_go |=> psr_q) else $error("prescaler clear lost in hold");
	stop_idle_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		cs == TMR_CS_STOP && !cnt_wr |=> count_q == $past(count_q))
		else $error("counter moved while stopped");
	pre_free_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		!psr_q |=> pre_q == $past(pre_q) + 1'b1) else $error("prescaler not free");
endmodule : tmr_core
`default_nettype wire

/* File: hw/tmr_pin_sync.sv */
/*
 * count pin synchroniser and edge detector; assumes the pin is sampled on
 * the rising clock edge and may toggle at any time.
 */
`timescale 1ns/100ps
`default_nettype none
module tmr_pin_sync (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_pin,
	input wire logic i_fall_sel,
	output logic o_edge
);
	logic meta_q;
	logic sync_q;
	logic last_q;
	// two-stage synchroniser, first stage feeds only the second
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= i_pin;
			sync_q <= meta_q;
		end
	end
	// edge detector history, reset to the idle pin level
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			last_q <= 1'b0;
		end else begin
			last_q <= sync_q;
		end
	end
	// one pulse per selected edge, unregistered so the counter moves two clocks after the first sample
	assign o_edge = i_fall_sel ? (last_q & ~sync_q) : (~last_q & sync_q);
endmodule : tmr_pin_sync
`default_nettype wire

/* File: inc/tmr_cfg.svh */
/*
 * register offsets, field positions, reset values and timing counts of the
 * timer control and prescaler block; assumes nothing of its surroundings.
 */
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
// word indices of the register words
`define TMR_OFF_CTRL_A 4'h0
`define TMR_OFF_CTRL_B 4'h1
`define TMR_OFF_COUNT 4'h2
`define TMR_OFF_CMP_A 4'h3
`define TMR_OFF_CMP_B 4'h4
`define TMR_OFF_MASK 4'h5
`define TMR_OFF_FLAGS 4'h6
`define TMR_OFF_SYNC 4'h7
// word index shift: byte address is four times the index
`define TMR_ADDR_SHIFT 2
// control register b fields
`define TMR_CB_FORCE_B 6
`define TMR_CB_WGM_HI 3
`define TMR_CB_CS_LSB 0
// control register a fields
`define TMR_CA_COMB_LSB 4
`define TMR_CA_COMA_LSB 6
`define TMR_CA_WGM_LSB 0
// mask and flag fields
`define TMR_IRQ_CMP_B 3
`define TMR_IRQ_CMP_A 2
`define TMR_IRQ_OVF 1
// sync register fields
`define TMR_SYNC_HOLD 7
`define TMR_SYNC_PSR 0
// valid bit masks
`define TMR_MASK_CTRL_A 8'hF3
`define TMR_MASK_CTRL_B 8'h0F
`define TMR_MASK_IRQ 8'h0E
`define TMR_MASK_SYNC 8'h81
// reset value and counter limits
`define TMR_RST_BYTE 8'h00
`define TMR_VAL_MAX 8'hFF
`define TMR_VAL_BOTTOM 8'h00
// prescaler width and taps (divisor 8, 64, 256, 1024 as low-bit masks)
`define TMR_PRE_W 10
`define TMR_TAP_8 10'h007
`define TMR_TAP_64 10'h03F
`define TMR_TAP_256 10'h0FF
`define TMR_TAP_1024 10'h3FF
`endif

/* File: inc/tmr_pkg.sv */
/*
 * types of the timer control and prescaler block; assumes tmr_cfg.svh.
 */
package tmr_pkg;
	typedef enum logic [2:0] {
		TMR_CS_STOP = 3'h0,
		TMR_CS_DIV1 = 3'h1,
		TMR_CS_DIV8 = 3'h2,
		TMR_CS_DIV64 = 3'h3,
		TMR_CS_DIV256 = 3'h4,
		TMR_CS_DIV1024 = 3'h5,
		TMR_CS_EXT_FALL = 3'h6,
		TMR_CS_EXT_RISE = 3'h7
	} tmr_clk_sel_t;
	// bus slave phase, one-hot
	typedef enum logic [1:0] {
		TMR_BUS_IDLE = 2'h1,
		TMR_BUS_DONE = 2'h2
	} tmr_bus_t;
endpackage : tmr_pkg

/* File: tb/tb_timer0_control_prescaler.sv */
/*
 * self-checking bench of the timer core: registers, prescaler, pin clock,
 * flags and irq; assumes tmr_core, tmr_pkg, tmr_cfg.svh and tmr_pin_src.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tmr_cfg.svh"
module tb_timer0_control_prescaler;
	import tmr_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [5:0] addr = 6'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic wait_rq;
	logic [1:0] resp;
	logic pin;
	logic gie = 1'b0;
	logic [2:0] vack = 3'h0;
	logic [2:0] irq;
	logic wave_a;
	logic wave_b;
	int n_mismatch = 0;
	int compares = 0;
	int seed = 32'hc33e;
	int cyc = 0;
	logic [7:0] v;
	logic [7:0] r;
	logic [1:0] rsp;
	logic w0;
	int t0;
	int e;
	int div;
	tmr_core #(.ADDR_W(6)) i_tmr_core (.I_CLOCK(clk), .I_NRST(nrst), .I_ADDRESS(addr),
		.I_READ(rd_en), .I_WRITE(wr_en), .I_WRITEDATA(wdata), .I_BYTEENABLE(4'hF),
		.O_READDATA(rdata), .O_WAITREQUEST(wait_rq), .O_RESPONSE(resp),
		.I_EXT_COUNT_PIN(pin), .I_GLOBAL_IRQ_EN(gie), .I_VECTOR_ACK(vack), .O_IRQ(irq),
		.O_WAVE_OUT_A(wave_a), .O_WAVE_OUT_B(wave_b));
	tmr_pin_src i_tmr_pin_src (.i_clk(clk), .o_pin(pin));
	// ****************************************
	// clock, cycle count and watchdog
	// ****************************************
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
	end
	initial begin
		#200000;
		n_mismatch++;
		close_out();
	end
	// ****************************************
	// shared tasks and expectation functions
	// ****************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d);
		int n;
		@(posedge clk);
		addr <= {idx, 2'b00};
		rd_en <= ~wr;
		wr_en <= wr;
		wdata <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wait_rq !== 1'b0 && n < 50);
		if (n >= 50) n_mismatch++;
		r = rdata[7:0];
		rsp = resp;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
	endtask : bus
	// write then read back against the expected value
	task automatic wr_rd(input logic [3:0] idx, input logic [7:0] d, input logic [7:0] exp);
		bus(1'b1, idx, d);
		bus(1'b0, idx, 8'h00);
		chk(r, exp);
	endtask : wr_rd
	function automatic logic [7:0] ok_range(input int cnt, input int el, input int n);
		return ((cnt >= el / n - 1) && (cnt <= el / n + 1)) ? 8'h01 : 8'h00;
	endfunction : ok_range
	task automatic close_out();
		if (n_mismatch == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		// reset values and unmapped words
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, i[3:0], 8'h00);
			chk(r, `TMR_RST_BYTE);
		end
		bus(1'b0, 4'h8, 8'h00);
		chk({6'h0, rsp}, 8'h03);
		bus(1'b1, 4'hC, 8'h5A);
		chk({6'h0, rsp}, 8'h03);
		// reserved bits and strobe read as zero
		wr_rd(`TMR_OFF_CTRL_B, 8'hF0, 8'h00);
		wr_rd(`TMR_OFF_MASK, 8'hFF, `TMR_MASK_IRQ);
		wr_rd(`TMR_OFF_MASK, 8'h00, 8'h00);
		for (int i = 0; i < 8; i++) begin
			v = $random(seed);
			wr_rd(`TMR_OFF_COUNT + i % 3, v, v);
		end
		// prescaler taps: count tracks elapsed clocks over the divisor
		for (int cs = 2; cs < 6; cs++) begin
			div = (cs == 2) ? 8 : (cs == 3) ? 64 : (cs == 4) ? 256 : 1024;
			bus(1'b1, `TMR_OFF_COUNT, 8'h00);
			bus(1'b1, `TMR_OFF_CTRL_B, cs[7:0]);
			t0 = cyc;
			repeat (3 * div) @(posedge clk);
			bus(1'b1, `TMR_OFF_CTRL_B, 8'h00);
			e = cyc - t0;
			bus(1'b0, `TMR_OFF_COUNT, 8'h00);
			chk(ok_range(r, e, div), 8'h01);
		end
		// sync hold keeps prescaler clear and halts counting
		wr_rd(`TMR_OFF_SYNC, 8'h01, 8'h00);
		wr_rd(`TMR_OFF_SYNC, 8'h81, 8'h81);
		bus(1'b1, `TMR_OFF_COUNT, 8'h00);
		bus(1'b1, `TMR_OFF_CTRL_B, 8'h02);
		repeat (100) @(posedge clk);
		bus(1'b0, `TMR_OFF_COUNT, 8'h00);
		chk(r, 8'h00);
		wr_rd(`TMR_OFF_SYNC, 8'h00, 8'h00);
		repeat (100) @(posedge clk);
		bus(1'b0, `TMR_OFF_COUNT, 8'h00);
		chk((r != 8'h00) ? 8'h01 : 8'h00, 8'h01);
		// pin clock on rising then falling edges, never prescaled
		bus(1'b1, `TMR_OFF_CTRL_B, 8'h00);
		bus(1'b1, `TMR_OFF_COUNT, 8'h10);
		bus(1'b1, `TMR_OFF_CTRL_B, {5'h0, TMR_CS_EXT_RISE});
		i_tmr_pin_src.pulses(5);
		bus(1'b0, `TMR_OFF_COUNT, 8'h00);
		chk(r, 8'h15);
		bus(1'b1, `TMR_OFF_CTRL_B, {5'h0, TMR_CS_EXT_FALL});
		i_tmr_pin_src.pulses(3);
		bus(1'b1, `TMR_OFF_CTRL_B, 8'h00);
		bus(1'b0, `TMR_OFF_COUNT, 8'h00);
		chk(r, 8'h18);
		// compare matches raise flags, irq gated by mask and global enable
		v = 8'd40 + ($unsigned($random(seed)) % 160);
		bus(1'b1, `TMR_OFF_CMP_A, v);
		bus(1'b1, `TMR_OFF_CMP_B, v - 8'd2);
		bus(1'b1, `TMR_OFF_COUNT, v - 8'd4);
		bus(1'b1, `TMR_OFF_MASK, 8'h04);
		gie <= 1'b1;
		bus(1'b1, `TMR_OFF_CTRL_B, 8'h01);
		for (int i = 0; i < 20 && !r[2]; i++) bus(1'b0, `TMR_OFF_FLAGS, 8'h00);
		bus(1'b1, `TMR_OFF_CTRL_B, 8'h00);
		bus(1'b0, `TMR_OFF_FLAGS, 8'h00);
		chk(r, 8'h0C);
		chk({5'h0, irq}, 8'h02);
		gie <= 1'b0;
		repeat (3) @(posedge clk);
		chk({5'h0, irq}, 8'h00);
		wr_rd(`TMR_OFF_FLAGS, 8'h08, 8'h04);
		@(posedge clk);
		vack <= 3'h2;
		@(posedge clk);
		vack <= 3'h0;
		bus(1'b0, `TMR_OFF_FLAGS, 8'h00);
		chk(r, 8'h00);
		// overflow at max in normal mode
		bus(1'b1, `TMR_OFF_COUNT, 8'hFC);
		bus(1'b1, `TMR_OFF_CTRL_B, 8'h01);
		repeat (20) @(posedge clk);
		bus(1'b1, `TMR_OFF_CTRL_B, 8'h00);
		wr_rd(`TMR_OFF_FLAGS, 8'h00, 8'h02);
		chk(r, 8'h02);
		wr_rd(`TMR_OFF_FLAGS, 8'h02, 8'h00);
		// forced compare b in clear-on-match mode toggles output only
		bus(1'b1, `TMR_OFF_CTRL_A, 8'h52);
		bus(1'b0, `TMR_OFF_COUNT, 8'h00);
		v = r;
		w0 = wave_b;
		bus(1'b1, `TMR_OFF_CTRL_B, 8'h40);
		repeat (3) @(posedge clk);
		chk({7'h0, wave_b}, {7'h0, ~w0});
		bus(1'b0, `TMR_OFF_FLAGS, 8'h00);
		chk(r, 8'h00);
		bus(1'b0, `TMR_OFF_COUNT, 8'h00);
		chk(r, v);
		// compare a match toggles output a and clears the counter in ctc
		w0 = wave_a;
		bus(1'b1, `TMR_OFF_CMP_A, 8'h80);
		bus(1'b1, `TMR_OFF_COUNT, 8'h7E);
		bus(1'b1, `TMR_OFF_CTRL_B, 8'h01);
		repeat (5) @(posedge clk);
		bus(1'b1, `TMR_OFF_CTRL_B, 8'h00);
		chk({7'h0, wave_a}, {7'h0, ~w0});
		bus(1'b0, `TMR_OFF_COUNT, 8'h00);
		chk(r, 8'h05);
		// phase correct mode flags overflow at bottom, not at max
		bus(1'b1, `TMR_OFF_CTRL_A, 8'h01);
		bus(1'b1, `TMR_OFF_COUNT, 8'h02);
		bus(1'b1, `TMR_OFF_FLAGS, 8'h0E);
		bus(1'b1, `TMR_OFF_CTRL_B, 8'h01);
		repeat (300) @(posedge clk);
		bus(1'b0, `TMR_OFF_FLAGS, 8'h00);
		chk(r & 8'h02, 8'h00);
		repeat (300) @(posedge clk);
		bus(1'b1, `TMR_OFF_CTRL_B, 8'h00);
		bus(1'b0, `TMR_OFF_FLAGS, 8'h00);
		chk(r & 8'h02, 8'h02);
		close_out();
	end
endmodule : tb_timer0_control_prescaler
`default_nettype wire

/* File: tb/tmr_pin_src.sv */
/*
 * model of the external count clock source on the count pin.
 * assumes the system clock of the block and a caller that asks for pulses.
 */
`timescale 1ns/100ps
`default_nettype none
module tmr_pin_src (
	input wire logic i_clk,
	output logic o_pin
);
	// pin idles low and stands still between bursts
	initial begin
		o_pin = 1'b0;
	end
	// each half period lasts three system clocks, above the 2.5 margin
	task pulses(input int n);
		for (int k = 0; k < n; k++) begin
			repeat (3) @(posedge i_clk);
			o_pin <= 1'b1;
			repeat (3) @(posedge i_clk);
			o_pin <= 1'b0;
		end
		// settle so the pin is stable before clocking is switched
		repeat (3) @(posedge i_clk);
	endtask : pulses
endmodule : tmr_pin_src
`default_nettype wire
